// ===== verilog/skip_set_sub_instr_exec.v
// Purpose: Executes set, increment-skip, skip-test, subtract and nibble-swap ops
// Assumes: One op per instruction cycle; memory read data valid with the op
// Notes:   A taken skip inserts one dummy cycle and discards the prefetched op
//          Ops offered during the dummy cycle are dropped, so fetch must not park one there
//          Low ce freezes every register, the dummy cycle included
//          Subtract carry is set for no borrow
`timescale 1ns/1ps
`include "skip_set_sub_defines.vh"
module skip_set_sub_instr_exec (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  // Decoded op
  input  wire       op_valid,
  input  wire [3:0] op_code,
  input  wire [2:0] bit_sel,
  input  wire [7:0] imm_data,
  // Data memory
  input  wire [7:0] mem_rdata,
  output reg  [7:0] mem_wdata,
  output reg        mem_we,
  // Accumulator and flags
  output reg  [7:0] acc,
  output reg        overflow_flag,
  output reg        zero_flag,
  output reg        aux_carry_flag,
  output reg        carry_flag,
  // Pipeline control
  output wire       discard_prefetch,
  output wire       busy,
  output reg        skip_taken
);
  // Op cycle, or the dummy cycle that stands in for a discarded prefetch
  localparam ST_EXEC  = 1'b0;
  localparam ST_DUMMY = 1'b1;
  reg        state;
  reg        next_state;
  reg  [7:0] next_mem_wdata;
  reg        next_mem_we;
  reg  [7:0] next_acc;
  reg        next_skip;
  reg        upd_flags;
  reg  [7:0] sub_b;
  wire [7:0] incr;
  wire [7:0] bit_mask;
  wire [7:0] swapped;
  wire [7:0] diff;
  wire       d_ov;
  wire       d_z;
  wire       d_ac;
  wire       d_c;
  wire       take;
  wire       incr_zero;
  wire       bit_one;
  wire       byte_zero;
  reg  [3:0] next_flags;
  assign incr     = mem_rdata + 8'h01;
  assign bit_mask = 8'h01 << bit_sel;
  assign swapped  = {mem_rdata[3:0], mem_rdata[7:4]};
  // Test results shared by the skip ops
  assign incr_zero = (incr == 8'h00);
  assign bit_one   = |(mem_rdata & bit_mask);
  assign byte_zero = (mem_rdata == 8'h00);
  // In the dummy cycle the prefetched op is dropped and no new op is taken
  assign discard_prefetch = (state == ST_DUMMY);
  assign busy             = (state == ST_DUMMY);
  // Gating the take with ce keeps a frozen cycle from looking like an executed op
  assign take = ce & op_valid & (state == ST_EXEC);

  // Immediate form takes its operand from the op, all others from memory
  always @* begin
    if (op_code == `OP_SUB_IMM) begin
      sub_b = imm_data;
    end else begin
      sub_b = mem_rdata;
    end
  end

  // One subtractor serves the accumulator, memory-destination and immediate forms
  sub_alu u_sub_alu (
    .a    (acc),
    .b    (sub_b),
    .diff (diff),
    .ov   (d_ov),
    .z    (d_z),
    .ac   (d_ac),
    .c    (d_c)
  );

  // Every result is decided here and registered below, so data outputs come from flops
  always @* begin
    next_mem_wdata = mem_wdata;
    next_mem_we    = 1'b0;
    next_acc       = acc;
    next_skip      = 1'b0;
    upd_flags      = 1'b0;
    next_state     = ST_EXEC;
    if (take) begin
      case (op_code)
        `OP_SET_BYTE: begin
          next_mem_wdata = `BYTE_ALL_ONES;
          next_mem_we    = 1'b1;
        end
        `OP_SET_BIT: begin
          next_mem_wdata = mem_rdata | bit_mask;
          next_mem_we    = 1'b1;
        end
        `OP_INC_MEM_SKIP: begin
          next_mem_wdata = incr;
          next_mem_we    = 1'b1;
          next_skip      = incr_zero;
        end
        `OP_INC_ACC_SKIP: begin
          next_acc  = incr;
          next_skip = incr_zero;
        end
        `OP_SKIP_BIT_ONE: begin
          next_skip = bit_one;
        end
        `OP_SUB_TO_ACC, `OP_SUB_IMM: begin
          next_acc  = diff;
          upd_flags = 1'b1;
        end
        `OP_SUB_TO_MEM: begin
          next_mem_wdata = diff;
          next_mem_we    = 1'b1;
          upd_flags      = 1'b1;
        end
        `OP_SKIP_ZERO: begin
          next_skip = byte_zero;
        end
        `OP_SWAP_MEM: begin
          next_mem_wdata = swapped;
          next_mem_we    = 1'b1;
        end
        `OP_SWAP_ACC: begin
          next_acc = swapped;
        end
        `OP_MOVE_SKIP: begin
          next_acc  = mem_rdata;
          next_skip = byte_zero;
        end
        default: begin
          // Code zero and unused codes do nothing
          next_skip = 1'b0;
        end
      endcase
      // False condition stays in EXEC: one cycle
      if (next_skip) begin
        next_state = ST_DUMMY;
      end
    end
  end

  // Only subtracts touch flags; every other op carries them over
  always @* begin
    next_flags               = 4'h0;
    next_flags[`FLAG_OV_BIT] = upd_flags ? d_ov : overflow_flag;
    next_flags[`FLAG_Z_BIT]  = upd_flags ? d_z : zero_flag;
    next_flags[`FLAG_AC_BIT] = upd_flags ? d_ac : aux_carry_flag;
    next_flags[`FLAG_C_BIT]  = upd_flags ? d_c : carry_flag;
  end

  // Sequencer and skip pulse move together so the dummy cycle always follows a true skip
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= ST_EXEC;
      skip_taken <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      skip_taken <= next_skip;
    end
  end

  // Write port: the strobe is a one-cycle pulse, the data holds between writes
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_wdata <= `WDATA_RESET;
      mem_we    <= 1'b0;
    end else if (ce) begin
      mem_wdata <= next_mem_wdata;
      mem_we    <= next_mem_we;
    end
  end

  // Skip ops that load the accumulator write it in their first cycle, not the dummy one
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc <= `ACC_RESET;
    end else if (ce) begin
      acc <= next_acc;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overflow_flag  <= `FLAG_RESET;
      zero_flag      <= `FLAG_RESET;
      aux_carry_flag <= `FLAG_RESET;
      carry_flag     <= `FLAG_RESET;
    end else if (ce) begin
      overflow_flag  <= next_flags[`FLAG_OV_BIT];
      zero_flag      <= next_flags[`FLAG_Z_BIT];
      aux_carry_flag <= next_flags[`FLAG_AC_BIT];
      carry_flag     <= next_flags[`FLAG_C_BIT];
    end
  end
endmodule // skip_set_sub_instr_exec

// ===== verilog/skip_set_sub_defines.vh
// Purpose: Constants for the set/skip/subtract execution block
// Assumes: Opcode codes are local to this block's decode port
// Notes:   Included by bare name
`ifndef SKIP_SET_SUB_DEFINES_VH
`define SKIP_SET_SUB_DEFINES_VH
`define OP_NONE          4'h0
`define OP_SET_BYTE      4'h1
`define OP_SET_BIT       4'h2
`define OP_INC_MEM_SKIP  4'h3
`define OP_INC_ACC_SKIP  4'h4
`define OP_SKIP_BIT_ONE  4'h5
`define OP_SUB_TO_ACC    4'h6
`define OP_SUB_TO_MEM    4'h7
`define OP_SUB_IMM       4'h8
`define OP_SKIP_ZERO     4'h9
`define OP_SWAP_MEM      4'hA
`define OP_SWAP_ACC      4'hB
`define OP_MOVE_SKIP     4'hC
`define BYTE_ALL_ONES    8'hFF
`define ACC_RESET        8'h00
`define FLAG_OV_BIT      3
`define FLAG_Z_BIT       2
`define FLAG_AC_BIT      1
`define FLAG_C_BIT       0
`define WDATA_RESET      8'h00
`define FLAG_RESET       1'b0
`endif

// ===== verilog/sub_alu.v
// Purpose: Subtractor a + ~b + 1 with the four arithmetic flags
// Assumes: 8-bit operands
// Notes:   Combinational
`timescale 1ns/1ps
module sub_alu (
  // Operands
  input  wire [7:0] a,
  input  wire [7:0] b,
  // Result
  output wire [7:0] diff,
  output wire       ov,
  output wire       z,
  output wire       ac,
  output wire       c
);
  wire [8:0] full;
  wire [4:0] low;
  assign full = {1'b0, a} + {1'b0, ~b} + 9'h001;
  assign low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
  assign diff = full[7:0];
  assign c    = full[8];
  assign ac   = low[4];
  assign z    = (full[7:0] == 8'h00);
  // Operands of opposite sign and result sign differs from a
  assign ov   = (a[7] ^ b[7]) & (a[7] ^ full[7]);
endmodule // sub_alu

// ===== testbench/skip_set_sub_properties.sv
// Purpose: Port assertions for skip_set_sub_instr_exec
// Assumes: One clock domain, rst active high
// Notes: Bound to the design at the foot of this file
`timescale 1ns/1ps
`include "skip_set_sub_defines.vh"
module skip_set_sub_properties (
  // Clock, reset and decoded op
  input logic       clk_sys, rst, ce, op_valid,
  input logic [3:0] op_code,
  input logic [2:0] bit_sel,
  input logic [7:0] imm_data, mem_rdata, mem_wdata, acc,
  // Strobes and flags
  input logic       mem_we, overflow_flag, zero_flag, aux_carry_flag, carry_flag, discard_prefetch, busy, skip_taken
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire       t = ce & op_valid & ~busy;
  wire [3:0] f = {overflow_flag, zero_flag, aux_carry_flag, carry_flag};
  a_set_byte: assert property (t && op_code == `OP_SET_BYTE |=> mem_we && mem_wdata == 8'hFF && $stable(f))
    else $error("byte set wrong");
  a_set_bit: assert property (t && op_code == `OP_SET_BIT |=> mem_wdata == ($past(mem_rdata) | 8'h01 << $past(bit_sel)))
    else $error("bit set wrong");
  a_inc_mem: assert property (t && op_code == `OP_INC_MEM_SKIP |=> mem_we && mem_wdata == $past(mem_rdata) + 8'h01 && skip_taken == ($past(mem_rdata) == 8'hFF))
    else $error("increment to memory wrong");
  a_skip_discard: assert property (skip_taken |-> discard_prefetch)
    else $error("no discard on skip");
  a_one_dummy: assert property (busy && ce |=> !busy)
    else $error("dummy cycle too long");
  a_inc_acc: assert property (t && op_code == `OP_INC_ACC_SKIP |=> !mem_we && acc == $past(mem_rdata) + 8'h01)
    else $error("increment to accumulator wrong");
  a_bit_one: assert property (t && op_code == `OP_SKIP_BIT_ONE |=> !mem_we && skip_taken == $past(mem_rdata[bit_sel]))
    else $error("bit test skip wrong");
  a_sub_acc: assert property (t && op_code == `OP_SUB_TO_ACC |=> acc == $past(acc) - $past(mem_rdata) && carry_flag == ($past(acc) >= $past(mem_rdata)))
    else $error("subtract wrong");
  a_skip_zero: assert property (t && op_code == `OP_SKIP_ZERO |=> !mem_we && skip_taken == ($past(mem_rdata) == 8'h00))
    else $error("zero test skip wrong");
  a_no_skip: assert property (!skip_taken |-> !busy)
    else $error("busy without skip");
  cover property (t && op_code == `OP_INC_MEM_SKIP ##1 skip_taken);
  cover property (t && op_code == `OP_SUB_TO_MEM ##1 mem_we);
  cover property (busy && op_valid);
endmodule // skip_set_sub_properties
bind skip_set_sub_instr_exec skip_set_sub_properties i_chk (.*);

// ===== testbench/testbench.sv
// Purpose: Directed bench for skip_set_sub_instr_exec
// Assumes: Answer registered on the taking edge, checked 1 ns after it
// Notes: Only fixed waits, so no scenario can hang
`timescale 1ns/1ps
`include "skip_set_sub_defines.vh"
module testbench;
  reg        clk_sys = 0, rst = 1, ce = 1, op_valid = 0;
  reg  [3:0] op_code = 0;
  reg  [2:0] bit_sel = 0;
  reg  [7:0] imm_data = 0, mem_rdata = 0;
  wire [7:0] mem_wdata, acc;
  wire       mem_we, overflow_flag, zero_flag, aux_carry_flag, carry_flag, discard_prefetch, busy, skip_taken;
  int        n_fail = 0, comparisons = 0;
  skip_set_sub_instr_exec i_dut (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task ck(input [15:0] s, input [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Immediate ops see the inverse on the memory bus, so a wrong source shows
  task x(input [3:0] c, input [7:0] d, input [2:0] b);
    @(posedge clk_sys);
    op_code <= c;
    mem_rdata <= (c == `OP_SUB_IMM) ? ~d : d;
    imm_data <= d;
    bit_sel <= b;
    op_valid <= 1;
    @(posedge clk_sys);
    op_valid <= 0;
    mem_rdata <= ~d;
    #1;
  endtask
  task t_skip(input [3:0] c, input [7:0] d, input [2:0] b, input s);
    x(c, d, b);
    ck(skip_taken, s);
    ck({busy, discard_prefetch}, {s, s});
  endtask
  function [11:0] sx(input [7:0] a, input [7:0] b);
    reg [7:0] r;
    r = a + ~b + 8'h01;
    sx = {r, (a[7] ^ b[7]) & (r[7] ^ a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction
  task t_set;
    x(`OP_SET_BYTE, 8'h5A, 0);
    ck({mem_we, mem_wdata}, 9'h1FF);
    for (int b = 0; b < 8; b++) begin
      x(`OP_SET_BIT, 8'h24, b);
      ck(mem_wdata, 8'h24 | 8'h01 << b);
    end
  endtask
  // The op stays offered into the dummy cycle, where it must be dropped
  task t_incr;
    @(posedge clk_sys);
    op_code <= `OP_INC_MEM_SKIP;
    mem_rdata <= 8'hFF;
    op_valid <= 1;
    @(posedge clk_sys);
    mem_rdata <= 8'h00;
    #1;
    ck({mem_we, skip_taken, mem_wdata}, 10'h300);
    @(posedge clk_sys);
    op_valid <= 0;
    #1;
    ck({mem_we, busy, mem_wdata}, 10'h000);
    t_skip(`OP_INC_MEM_SKIP, 8'h7F, 0, 0);
    ck(mem_wdata, 8'h80);
  endtask
  // With ce low an offered byte set must not land
  task t_hold;
    @(posedge clk_sys);
    ce <= 0;
    x(`OP_SET_BYTE, 8'h00, 0);
    ck({mem_we, mem_wdata}, 9'h080);
    @(posedge clk_sys);
    ce <= 1;
  endtask
  task t_tests;
    t_skip(`OP_INC_ACC_SKIP, 8'hFF, 0, 1);
    ck({mem_we, acc}, 9'h000);
    t_skip(`OP_INC_ACC_SKIP, 8'h41, 0, 0);
    ck(acc, 8'h42);
    for (int b = 0; b < 8; b++) t_skip(`OP_SKIP_BIT_ONE, 8'hA5, b, (8'hA5 >> b) & 8'h01);
    t_skip(`OP_SKIP_ZERO, 8'h00, 0, 1);
    t_skip(`OP_SKIP_ZERO, 8'h80, 0, 0);
    x(`OP_SWAP_ACC, 8'h3C, 0);
    ck(acc, 8'hC3);
    x(`OP_SWAP_MEM, 8'h3C, 0);
    ck({mem_we, mem_wdata}, 9'h1C3);
    t_skip(`OP_MOVE_SKIP, 8'h00, 0, 1);
    ck(acc, 8'h00);
  endtask
  task t_sub;
    reg [23:0] av, bv;
    reg [11:0] e;
    av = 24'h058023;
    bv = 24'h030123;
    for (int i = 0; i < 9; i++) begin
      t_skip(`OP_MOVE_SKIP, av[i % 3 * 8 +: 8], 0, 0);
      e = sx(av[i % 3 * 8 +: 8], bv[i % 3 * 8 +: 8]);
      x(`OP_SUB_TO_ACC + i / 3, bv[i % 3 * 8 +: 8], 0);
      ck(i / 3 == 1 ? mem_wdata : acc, e[11:4]);
      ck({overflow_flag, zero_flag, aux_carry_flag, carry_flag}, e[3:0]);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    t_sub;
    t_set;
    t_incr;
    t_hold;
    t_tests;
    end_of_test;
  end
endmodule // testbench
